// file: logic/tmr_out_irq.v
// timer output units, channel flags and prioritized interrupt vector behind an apb slave
//
// Overview of operation
// - mode 0: output follows the software output bit at the write itself
// - mode 1: output set on channel match, held until another mode acts
// - mode 2 toggles/0-match resets; mode 3 sets/0-match resets
// - mode 4: output toggles on every channel match
// - mode 5: output cleared on channel match, held until another mode acts
// - mode 6 toggles/0-match sets; mode 7 clears/0-match sets
// - up counting: events at channel value and channel-0 value wrap
// - continuous counting: events at channel value and channel-0 value
// - up/down counting: matches act in either direction
// - two interrupt lines: channel 0 alone, the rest shared
// - capture mode: a capture sets the channel flag
// - compare mode: a channel match sets the channel flag
// - software may set or clear every channel flag
// - flag requests only with its enable and global enable set
// - channel-0 flag highest, cleared when its request is serviced
// - channels 1 and up plus overflow merge into the shared line
// - vector holds code of highest enabled pending flag only
// - any vector read or write clears the reported flag
// - remaining enabled flags reassert the shared line at once
// - codes: 0 none, 2 per channel step, 14 overflow
// - lower channel numbers win in the vector
// - in every mode, mode 0 included, output changes only on a clock edge
// - per-channel equal pulse plus channel-0 equal drive the output
// - hi-z function selected and pin high: all outputs high impedance
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "tmr_out_irq_consts.vh"

module tmr_out_irq #(
  parameter NCH = 7
) (
  // apb
  input  wire            pclk,
  input  wire            presetn,
  input  wire            psel,
  input  wire            penable,
  input  wire            pwrite,
  input  wire [7:0]      paddr,
  input  wire [31:0]     pwdata,
  output reg  [31:0]     prdata,
  output reg             pready,
  output reg             pslverr,
  // timer core events, same clock
  input  wire [NCH-1:0]  equal_x,
  input  wire [NCH-1:0]  cap_event,
  input  wire            overflow_event,
  // cpu side
  input  wire            global_irq_en,
  input  wire            irq0_ack,
  output reg             irq_chan0,
  output reg             irq_shared,
  // pins
  input  wire            hiz_ctrl_pin,
  output reg  [NCH-1:0]  chan_out,
  output reg  [NCH-1:0]  chan_out_oe
);

  reg  [NCH-1:0]   flag_r;
  wire [NCH-1:0]   flag_nxt;
  reg  [NCH-1:0]   ie_r;
  reg  [NCH-1:0]   ie_nxt;
  reg  [NCH-1:0]   bit_r;
  reg  [NCH-1:0]   bit_nxt;
  reg  [NCH-1:0]   cap_r;
  reg  [NCH-1:0]   cap_nxt;
  reg  [3*NCH-1:0] mode_r;
  reg  [3*NCH-1:0] mode_nxt;
  wire [NCH-1:0]   out_nxt;
  reg              ovf_flag_r;
  reg              ovf_flag_nxt;
  reg              ovf_ie_r;
  reg              hiz_fn_r;
  reg              hiz_meta_r;
  reg              hiz_sync_r;
  reg  [3:0]       vec_code;
  reg  [3:0]       vec_snap_r;
  reg  [31:0]      rd_mux;
  reg              rd_hit;
  reg  [NCH-1:0]   chan_wr_v;
  reg  [NCH-1:0]   svc_clr_v;
  integer          i;
  integer          j;
  integer          k;

  wire       setup    = psel & ~penable;
  wire       done     = psel & penable & pready;
  wire       wr_done  = done & pwrite;
  wire       vec_done = done & (paddr == `IRQ_VECTOR_OFS);
  wire       tc_wr    = wr_done & (paddr == `TMR_CTRL_OFS);

  // vector priority: scan high to low so the lowest channel lands last
  always @* begin
    vec_code = `VEC_NONE;
    if (ovf_flag_r & ovf_ie_r)
      vec_code = `VEC_OVF;
    for (j = NCH - 1; j >= 1; j = j - 1) begin
      if (flag_r[j] & ie_r[j])
        vec_code = {j[2:0], 1'b0};
    end
  end

  // read data and address decode, sampled in the setup cycle
  always @* begin
    rd_mux = `RST_DATA;
    rd_hit = 1'b0;
    for (k = 0; k < NCH; k = k + 1) begin
      if (paddr == `CHAN_CTRL_BASE + k[7:0] * `CHAN_CTRL_STRIDE) begin
        rd_hit = 1'b1;
        rd_mux[`CC_FLAG_BIT]                 = flag_r[k];
        rd_mux[`CC_OUTBIT_BIT]               = bit_r[k];
        rd_mux[`CC_OUTLVL_BIT]               = chan_out[k];
        rd_mux[`CC_IE_BIT]                   = ie_r[k];
        rd_mux[`CC_MODE_MSB:`CC_MODE_LSB]    = mode_r[3*k +: 3];
        rd_mux[`CC_CAP_BIT]                  = cap_r[k];
      end
    end
    if (paddr == `TMR_CTRL_OFS) begin
      rd_hit = 1'b1;
      rd_mux[`TC_OVF_FLAG_BIT] = ovf_flag_r;
      rd_mux[`TC_OVF_IE_BIT]   = ovf_ie_r;
      rd_mux[`TC_HIZ_FN_BIT]   = hiz_fn_r;
    end
    if (paddr == `IRQ_VECTOR_OFS) begin
      rd_hit = 1'b1;
      rd_mux[3:0] = vec_code;
    end
  end

  // per-channel register fields and service strobes
  always @* begin
    ie_nxt    = ie_r;
    bit_nxt   = bit_r;
    cap_nxt   = cap_r;
    mode_nxt  = mode_r;
    chan_wr_v = {NCH{1'b0}};
    svc_clr_v = {NCH{1'b0}};
    for (i = 0; i < NCH; i = i + 1) begin
      chan_wr_v[i] = wr_done & (paddr == `CHAN_CTRL_BASE + i[7:0] * `CHAN_CTRL_STRIDE);
      if (chan_wr_v[i]) begin
        ie_nxt[i]          = pwdata[`CC_IE_BIT];
        bit_nxt[i]         = pwdata[`CC_OUTBIT_BIT];
        cap_nxt[i]         = pwdata[`CC_CAP_BIT];
        mode_nxt[3*i +: 3] = pwdata[`CC_MODE_MSB:`CC_MODE_LSB];
      end
      // vector service clears the flag latched at setup, the ack clears channel 0
      if (i > 0)
        svc_clr_v[i] = vec_done & (vec_snap_r == {i[2:0], 1'b0});
      else
        svc_clr_v[i] = irq0_ack;
    end
  end

  // one flag and one output unit per channel; the unit sees the mode and
  // bit being written, so a new mode acts from the write edge on
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : gen_chan
      out_unit_next u_unit (
        .mode    (mode_nxt[3*g +: 3]),
        .sw_bit  (bit_nxt[g]),
        .eq_own  (equal_x[g]),
        .eq_zero (equal_x[0]),
        .cur     (chan_out[g]),
        .nxt     (out_nxt[g])
      );
      chan_flag_next u_flag (
        .cur      (flag_r[g]),
        .cap_mode (cap_r[g]),
        .wr       (chan_wr_v[g]),
        .wr_val   (pwdata[`CC_FLAG_BIT]),
        .svc_clr  (svc_clr_v[g]),
        .eq_own   (equal_x[g]),
        .cap_ev   (cap_event[g]),
        .nxt      (flag_nxt[g])
      );
    end
  endgenerate

  // overflow flag: write, vector clear, then event set wins
  always @* begin
    ovf_flag_nxt = ovf_flag_r;
    if (tc_wr)
      ovf_flag_nxt = pwdata[`TC_OVF_FLAG_BIT];
    if (vec_done && vec_snap_r == `VEC_OVF)
      ovf_flag_nxt = 1'b0;
    if (overflow_event)
      ovf_flag_nxt = 1'b1;
  end

  // channel state and outputs; all changes on the clock edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r     <= {NCH{1'b0}};
      ie_r       <= {NCH{1'b0}};
      bit_r      <= {NCH{1'b0}};
      cap_r      <= {NCH{1'b0}};
      mode_r     <= {3*NCH{1'b0}};
      chan_out   <= {NCH{1'b0}};
      ovf_flag_r <= 1'b0;
      ovf_ie_r   <= 1'b0;
      hiz_fn_r   <= 1'b0;
    end else begin
      flag_r     <= flag_nxt;
      ie_r       <= ie_nxt;
      bit_r      <= bit_nxt;
      cap_r      <= cap_nxt;
      mode_r     <= mode_nxt;
      chan_out   <= out_nxt;
      ovf_flag_r <= ovf_flag_nxt;
      if (tc_wr) begin
        ovf_ie_r <= pwdata[`TC_OVF_IE_BIT];
        hiz_fn_r <= pwdata[`TC_HIZ_FN_BIT];
      end
    end
  end

  // interrupt lines follow flag state with one register stage
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_chan0  <= 1'b0;
      irq_shared <= 1'b0;
    end else begin
      irq_chan0  <= flag_r[0] & ie_r[0] & global_irq_en;
      irq_shared <= (vec_code != `VEC_NONE) & global_irq_en;
    end
  end

  // hi-z pin is asynchronous: two flops before use
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hiz_meta_r  <= 1'b0;
      hiz_sync_r  <= 1'b0;
      chan_out_oe <= {NCH{1'b0}};
    end else begin
      hiz_meta_r  <= hiz_ctrl_pin;
      hiz_sync_r  <= hiz_meta_r;
      chan_out_oe <= {NCH{~(hiz_fn_r & hiz_sync_r)}};
    end
  end

  // apb: no wait states; data and vector code latched at setup so
  // the flag cleared is exactly the one the read returns
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata     <= `RST_DATA;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      vec_snap_r <= `VEC_NONE;
    end else begin
      pready <= setup;
      if (setup) begin
        prdata     <= pwrite ? `RST_DATA : rd_mux;
        pslverr    <= ~rd_hit;
        vec_snap_r <= vec_code;
      end else if (done) begin
        pslverr <= 1'b0;
      end
    end
  end

endmodule // tmr_out_irq

// next level of one output unit from its mode and the two equal pulses;
// where both pulses coincide the channel-0 action is applied last and wins
// mode comes from a whole-field write, so no decode glitch can reach the pin;
// software still steps through mode 7 so every mode seen in between is harmless
module out_unit_next (
  // mode and software bit
  input  wire [2:0] mode,
  input  wire       sw_bit,
  // equal pulses
  input  wire       eq_own,
  input  wire       eq_zero,
  // current and next level
  input  wire       cur,
  output reg        nxt
);

  always @* begin
    nxt = cur;
    case (mode)
      `MODE_OUTPUT: begin
        nxt = sw_bit;
      end

      `MODE_SET: begin
        if (eq_own)
          nxt = 1'b1;
      end

      `MODE_TOG_RST: begin
        if (eq_own)
          nxt = ~cur;
        if (eq_zero)
          nxt = 1'b0;
      end

      `MODE_SET_RST: begin
        if (eq_own)
          nxt = 1'b1;
        if (eq_zero)
          nxt = 1'b0;
      end

      `MODE_TOGGLE: begin
        if (eq_own)
          nxt = ~cur;
      end

      `MODE_RESET: begin
        if (eq_own)
          nxt = 1'b0;
      end

      `MODE_TOG_SET: begin
        if (eq_own)
          nxt = ~cur;
        if (eq_zero)
          nxt = 1'b1;
      end

      `MODE_RST_SET: begin
        if (eq_own)
          nxt = 1'b0;
        if (eq_zero)
          nxt = 1'b1;
      end

      default: begin
        nxt = cur;
      end
    endcase
  end

endmodule // out_unit_next

// next state of one channel flag: write, then service clear, then event;
// the event is applied last so a set wins over any clear in the same cycle
// a flag set by software is indistinguishable from one set by hardware
module chan_flag_next (
  // current state and mode
  input  wire cur,
  input  wire cap_mode,
  // software write
  input  wire wr,
  input  wire wr_val,
  // service clear
  input  wire svc_clr,
  // hardware events
  input  wire eq_own,
  input  wire cap_ev,
  // next state
  output reg  nxt
);

  always @* begin
    nxt = cur;
    if (wr)
      nxt = wr_val;
    if (svc_clr)
      nxt = 1'b0;
    if (cap_mode) begin
      if (cap_ev)
        nxt = 1'b1;
    end else begin
      if (eq_own)
        nxt = 1'b1;
    end
  end

endmodule // chan_flag_next

// file: logic/tmr_out_irq_consts.vh
// register offsets, field positions, codes and reset values of the timer output/irq block
`ifndef TMR_OUT_IRQ_CONSTS_VH
`define TMR_OUT_IRQ_CONSTS_VH

// register byte offsets
`define CHAN_CTRL_BASE   8'h00
`define CHAN_CTRL_STRIDE 8'h04
`define TMR_CTRL_OFS     8'h20
`define IRQ_VECTOR_OFS   8'h24

// chan_ctrl_reg fields
`define CC_FLAG_BIT      0
`define CC_OUTBIT_BIT    2
`define CC_OUTLVL_BIT    3
`define CC_IE_BIT        4
`define CC_MODE_LSB      5
`define CC_MODE_MSB      7
`define CC_CAP_BIT       8

// timer control fields
`define TC_OVF_FLAG_BIT  0
`define TC_OVF_IE_BIT    1
`define TC_HIZ_FN_BIT    2

// output modes
`define MODE_OUTPUT      3'h0
`define MODE_SET         3'h1
`define MODE_TOG_RST     3'h2
`define MODE_SET_RST     3'h3
`define MODE_TOGGLE      3'h4
`define MODE_RESET       3'h5
`define MODE_TOG_SET     3'h6
`define MODE_RST_SET     3'h7

// vector codes
`define VEC_NONE         4'h0
`define VEC_OVF          4'he

// reset values
`define RST_DATA         32'h0000_0000
`define RST_MODE         3'h0

`endif

// file: tb/tmr_out_irq_asserts.sv
// port-level checker for the timer output and interrupt block
`timescale 1ns/1ps
module tmr_out_irq_asserts #(
  parameter NCH = 7
) (
  // apb
  input logic            pclk,
  input logic            presetn,
  input logic            psel,
  input logic            penable,
  input logic            pwrite,
  input logic [31:0]     prdata,
  input logic            pready,
  input logic            pslverr,
  // events and requests
  input logic [NCH-1:0]  equal_x,
  input logic [NCH-1:0]  cap_event,
  input logic            global_irq_en,
  input logic            irq0_ack,
  input logic            irq_chan0,
  input logic            irq_shared,
  // pins
  input logic            hiz_ctrl_pin,
  input logic [NCH-1:0]  chan_out,
  input logic [NCH-1:0]  chan_out_oe
);
  logic wr_done;
  logic any_eq;
  assign wr_done = psel & penable & pwrite & pready;
  assign any_eq  = |equal_x;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_pin_low; !hiz_ctrl_pin [*5]; endsequence
  // a concurrent set would legally win over the ack
  sequence s_ack; irq0_ack && !equal_x[0] && !cap_event[0] && !(psel && penable); endsequence
  chk_setup_ready: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  chk_ready_access: assert property (pready |-> psel && penable ##1 !pready)
    else $error("ready outside single access cycle");
  chk_err_zero: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error response malformed");
  chk_gie_gates: assert property (!global_irq_en |=> !irq_chan0 && !irq_shared)
    else $error("request without global enable");
  chk_ack_clears: assert property (s_ack |-> ##2 !irq_chan0)
    else $error("channel 0 request survives ack");
  chk_oe_uniform: assert property (chan_out_oe == '0 || chan_out_oe == '1)
    else $error("output enables split");
  chk_oe_pin_low: assert property (s_pin_low |-> chan_out_oe == '1)
    else $error("outputs released with pin low");
  chk_out_cause: assert property ($changed(chan_out) |->
    $past(any_eq) || $past(wr_done) || $past(wr_done, 2))
    else $error("output moved without cause");
endmodule // tmr_out_irq_asserts

bind tmr_out_irq tmr_out_irq_asserts #(.NCH(NCH)) u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .prdata, .pready, .pslverr, .equal_x, .cap_event, .global_irq_en, .irq0_ack,
  .irq_chan0, .irq_shared, .hiz_ctrl_pin, .chan_out, .chan_out_oe);

// file: tb/tb_tmr_out_irq.sv
// register-level bench for the timer output and interrupt block
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module tb_tmr_out_irq;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0]  equal_x, cap_event, chan_out, chan_out_oe;
  logic        overflow_event, global_irq_en, irq0_ack, irq_chan0, irq_shared;
  logic        hiz_ctrl_pin, err, o, x;
  int          fail_count, n_tests;

  tmr_out_irq u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .equal_x, .cap_event, .overflow_event, .global_irq_en, .irq0_ack,
    .irq_chan0, .irq_shared, .hiz_ctrl_pin, .chan_out, .chan_out_oe);

  initial begin
    pclk = 0;
    forever #25 pclk = ~pclk;
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 40);
    if (k >= 40) begin
      fail_count++;
      $display("[FAIL] %0t apb request never answered", $time);
      tally_and_finish;
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 32'h0000_0000);
    `CHK(rd, e)
  endtask

  task automatic pulse(input logic [6:0] eq, input logic [6:0] cp, input logic ov);
    @(posedge pclk);
    equal_x <= eq;
    cap_event <= cp;
    overflow_event <= ov;
    @(posedge pclk);
    equal_x <= 0;
    cap_event <= 0;
    overflow_event <= 0;
    repeat (3) @(posedge pclk);
  endtask

  // z: channel-0 match, otherwise own match
  function automatic logic nxt(input int m, input logic o, input logic z);
    if (z) return (m == 2 || m == 3) ? 1'b0 : (m >= 6) ? 1'b1 : o;
    return (m == 1 || m == 3) ? 1'b1 : (m == 5 || m == 7) ? 1'b0 : ~o;
  endfunction

  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    #(50 * 4000);
    fail_count++;
    tally_and_finish;
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {equal_x, cap_event, overflow_event, global_irq_en, irq0_ack, hiz_ctrl_pin} = '0;
    presetn = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1;
    rdchk(8'h04, 32'h0000_0000);
    rdchk(8'h24, 32'h0000_0000);
    apb(0, 8'h30, 32'h0000_0000);
    `CHK(err, 1'b1)
    for (int b = 0; b < 2; b++) for (int m = 1; m < 8; m++) begin
      o = b[0];
      apb(1, 8'h04, {29'h0, o, 2'b0});
      repeat (2) @(posedge pclk);
      `CHK(chan_out[1], o)
      apb(1, 8'h04, {24'h0, 3'h7, 2'b0, o, 2'b0});
      apb(1, 8'h04, {24'h0, m[2:0], 2'b0, o, 2'b0});
      pulse(7'h02, 7'h00, 1'b0);
      x = nxt(m, o, 0);
      `CHK(chan_out[1], x)
      pulse(7'h01, 7'h00, 1'b0);
      `CHK(chan_out[1], nxt(m, x, 1))
    end
    global_irq_en <= 1;
    apb(1, 8'h04, 32'h0000_0010);
    apb(1, 8'h08, 32'h0000_0010);
    apb(1, 8'h20, 32'h0000_0002);
    pulse(7'h0e, 7'h00, 1'b1);
    `CHK(irq_shared, 1'b1)
    rdchk(8'h24, 32'h0000_0002);
    apb(1, 8'h24, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    `CHK(irq_shared, 1'b1)
    rdchk(8'h24, 32'h0000_000e);
    rdchk(8'h24, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    `CHK(irq_shared, 1'b0)
    rdchk(8'h0c, 32'h0000_0001);
    apb(1, 8'h14, 32'h0000_0011);
    rdchk(8'h24, 32'h0000_000a);
    apb(1, 8'h0c, 32'h0000_0000);
    rdchk(8'h0c, 32'h0000_0000);
    apb(1, 8'h10, 32'h0000_0100);
    pulse(7'h00, 7'h10, 1'b0);
    rdchk(8'h10, 32'h0000_0101);
    apb(1, 8'h00, 32'h0000_0011);
    repeat (3) @(posedge pclk);
    `CHK(irq_chan0, 1'b1)
    irq0_ack <= 1;
    @(posedge pclk);
    irq0_ack <= 0;
    repeat (3) @(posedge pclk);
    `CHK(irq_chan0, 1'b0)
    apb(1, 8'h00, 32'h0000_0011);
    global_irq_en <= 0;
    repeat (3) @(posedge pclk);
    `CHK(irq_chan0, 1'b0)
    apb(1, 8'h20, 32'h0000_0004);
    hiz_ctrl_pin <= 1;
    repeat (6) @(posedge pclk);
    `CHK(chan_out_oe, 7'h00)
    hiz_ctrl_pin <= 0;
    repeat (6) @(posedge pclk);
    `CHK(chan_out_oe, 7'h7f)
    tally_and_finish;
  end
endmodule // tb_tmr_out_irq
